// *** buck1_pkg.sv ***
// Constants, field layout and types for the first buck converter control block
package buck1_pkg;

  // ****************************************************************
  // Register indexes (byte address is four times the index)
  // ****************************************************************
  localparam logic [14:0] RAMP_CTRL_IDX = 15'h4056;
  localparam logic [14:0] ON_CFG_IDX = 15'h4058;
  localparam logic [14:0] SLEEP_CTRL_IDX = 15'h4059;
  localparam logic [14:0] SCALING_CTRL_IDX = 15'h405A;
  localparam logic [14:0] STATUS_IDX = 15'h4060;
  localparam int ADDR_W = 17;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int SLOT_LSB = 13;
  localparam int MODE_LSB = 8;
  localparam int SRC_LSB = 11;
  localparam int RATE_LSB = 14;
  localparam int VHI_LSB = 2;
  localparam int ST_MODE_LSB = 8;
  localparam int ST_ENABLE_BIT = 12;
  localparam int ST_SLEEP_BIT = 13;
  localparam int ST_SCALING_BIT = 14;

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic [2:0] ON_SLOT_RST = 3'h0;
  localparam logic [1:0] ON_MODE_RST = 2'h1;
  localparam logic [6:0] ON_VSEL_RST = 7'h00;
  localparam logic [2:0] SLEEP_SLOT_RST = 3'h0;
  localparam logic [1:0] SLEEP_MODE_RST = 2'h3;
  localparam logic [6:0] SLEEP_VSEL_RST = 7'h00;
  localparam logic [1:0] SRC_RST = 2'h0;
  localparam logic [6:0] SCALING_VSEL_RST = 7'h00;
  localparam logic [1:0] RATE_RST = 2'h2;

  // ****************************************************************
  // Codes
  // ****************************************************************
  localparam logic [2:0] SLOT_OFF = 3'h0;
  localparam logic [2:0] SLOT_LAST = 3'h5;
  localparam logic [2:0] SLOT_HWEN1 = 3'h6;
  localparam logic [2:0] SLOT_HWEN2 = 3'h7;
  localparam logic [2:0] SLP_TS5 = 3'h0;
  localparam logic [2:0] SLP_TS3 = 3'h6;
  localparam logic [2:0] SLP_TS1 = 3'h7;
  localparam logic [2:0] SLOT_NUM_1 = 3'h1;
  localparam logic [2:0] SLOT_NUM_3 = 3'h3;
  localparam logic [2:0] SLOT_NUM_5 = 3'h5;
  localparam logic [2:0] SLP_DIS_BASE = 3'h6;
  localparam logic [6:0] VSEL_MIN_CODE = 7'h08;
  localparam logic [6:0] VSEL_MAX_CODE = 7'h68;

  typedef enum logic [1:0] {
    MODE_FCCM = 2'b00,
    MODE_AUTO = 2'b01,
    MODE_LDO = 2'b10,
    MODE_HYST = 2'b11
  } opmode_t;

  typedef enum logic [1:0] {
    SRC_OFF = 2'b00,
    SRC_SOFTWARE = 2'b01,
    SRC_HW1 = 2'b10,
    SRC_HW2 = 2'b11
  } scaling_src_t;

  typedef enum logic [1:0] {
    RATE_32US = 2'b00,
    RATE_16US = 2'b01,
    RATE_8US = 2'b10,
    RATE_IMMEDIATE = 2'b11
  } ramp_rate_t;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int STEP_32US_NS = 32000;
  localparam int STEP_16US_NS = 16000;
  localparam int STEP_8US_NS = 8000;
  localparam int CYC_32US = (STEP_32US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_16US = (STEP_16US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_8US = (STEP_8US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 12;

endpackage

// *** buck1_ramp_if.sv ***
// Target and ramp-rate hand-off between control and the voltage stepper
`timescale 1ns/1ps
interface buck1_ramp_if;
  logic [6:0] target;
  buck1_pkg::ramp_rate_t rate;
  logic [6:0] level;
  logic settled;

  modport ctl (output target, output rate, input level, input settled);
  modport ramp (input target, input rate, output level, output settled);
endinterface

// *** buck1_ramp.sv ***
// Voltage code stepper: walks the level toward the target at the ramp rate
`timescale 1ns/1ps
module buck1_ramp (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control side
  buck1_ramp_if.ramp rif
);

  logic [6:0] level_q;
  logic [6:0] level_d;
  logic [buck1_pkg::CNT_W-1:0] cnt_q;
  logic [buck1_pkg::CNT_W-1:0] cnt_d;
  logic [buck1_pkg::CNT_W-1:0] limit;

  // Cycles between steps for the chosen rate
  always_comb begin
    case (rif.rate)
      buck1_pkg::RATE_32US: limit = buck1_pkg::CNT_W'(buck1_pkg::CYC_32US - 1);
      buck1_pkg::RATE_16US: limit = buck1_pkg::CNT_W'(buck1_pkg::CYC_16US - 1);
      default: limit = buck1_pkg::CNT_W'(buck1_pkg::CYC_8US - 1);
    endcase
  end

  // One code step per period, or a jump when immediate
  always_comb begin
    level_d = level_q;
    cnt_d = '0;
    if (rif.rate == buck1_pkg::RATE_IMMEDIATE) begin
      level_d = rif.target;
    end else if (level_q != rif.target) begin
      if (cnt_q >= limit) begin
        // Counter restarts per step so a rate change applies at once
        level_d = (level_q < rif.target) ? level_q + 7'h01 : level_q - 7'h01;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  // Stepper state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= buck1_pkg::VSEL_MIN_CODE;
      cnt_q <= '0;
    end else begin
      level_q <= level_d;
      cnt_q <= cnt_d;
    end
  end

  assign rif.level = level_q;
  assign rif.settled = (level_q == rif.target);

endmodule

// *** buck1_ctrl.sv ***
// First buck converter sequencing, mode and voltage control with APB registers
`timescale 1ns/1ps
module buck1_ctrl (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [buck1_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Hardware pins, asynchronous
  input wire logic hw_enable1,
  input wire logic hw_enable2,
  input wire logic hw_scaling1,
  input wire logic hw_scaling2,
  // Sequencer, same clock
  input wire logic seq_startup_pulse,
  input wire logic seq_sleep_pulse,
  input wire logic seq_wake_pulse,
  input wire logic [2:0] seq_slot,
  // Boot memory load, same clock
  input wire logic boot_load_pulse,
  input wire logic [4:0] boot_on_vsel_hi,
  // Converter controls
  output logic buck_enable,
  output logic [1:0] buck_opmode,
  output logic [6:0] buck_voltage_code,
  output logic buck_settled
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [3:0] pin_meta_q;
  logic [3:0] pin_sync_q;

  // Two flops per pin; only the second stage is used
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_q <= 4'h0;
      pin_sync_q <= 4'h0;
    end else begin
      pin_meta_q <= {hw_scaling2, hw_scaling1, hw_enable2, hw_enable1};
      pin_sync_q <= pin_meta_q;
    end
  end

  logic hwen1_s;
  logic hwen2_s;
  logic hwsc1_s;
  logic hwsc2_s;
  assign hwen1_s = pin_sync_q[0];
  assign hwen2_s = pin_sync_q[1];
  assign hwsc1_s = pin_sync_q[2];
  assign hwsc2_s = pin_sync_q[3];

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [2:0] buck1_on_timeslot_q, buck1_on_timeslot_d;
  logic [1:0] buck1_on_opmode_q, buck1_on_opmode_d;
  logic [6:0] buck1_on_voltage_code_q, buck1_on_voltage_code_d;
  logic [2:0] buck1_sleep_timeslot_q, buck1_sleep_timeslot_d;
  logic [1:0] buck1_sleep_opmode_q, buck1_sleep_opmode_d;
  logic [6:0] buck1_sleep_voltage_code_q, buck1_sleep_voltage_code_d;
  logic [1:0] buck1_scaling_source_q, buck1_scaling_source_d;
  logic [6:0] buck1_scaling_voltage_code_q, buck1_scaling_voltage_code_d;
  logic [1:0] buck1_ramp_rate_q, buck1_ramp_rate_d;

  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic [14:0] idx;
  logic aligned;
  logic hit_ramp, hit_on, hit_sleep, hit_scaling, hit_status, mapped;
  logic wr_en;
  logic [15:0] rd_word;
  logic [15:0] status_word;

  assign idx = paddr[buck1_pkg::ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign hit_ramp = aligned && (idx == buck1_pkg::RAMP_CTRL_IDX);
  assign hit_on = aligned && (idx == buck1_pkg::ON_CFG_IDX);
  assign hit_sleep = aligned && (idx == buck1_pkg::SLEEP_CTRL_IDX);
  assign hit_scaling = aligned && (idx == buck1_pkg::SCALING_CTRL_IDX);
  assign hit_status = aligned && (idx == buck1_pkg::STATUS_IDX);
  assign mapped = hit_ramp | hit_on | hit_sleep | hit_scaling | hit_status;
  // Write lands only on the edge that sees pready high
  assign wr_en = psel && penable && pready_q && pwrite && mapped;

  // Read mux; unassigned bits stay zero
  always_comb begin
    rd_word = 16'h0000;
    if (hit_ramp) begin
      rd_word[buck1_pkg::RATE_LSB +: 2] = buck1_ramp_rate_q;
    end else if (hit_on) begin
      rd_word[buck1_pkg::SLOT_LSB +: 3] = buck1_on_timeslot_q;
      rd_word[buck1_pkg::MODE_LSB +: 2] = buck1_on_opmode_q;
      rd_word[6:0] = buck1_on_voltage_code_q;
    end else if (hit_sleep) begin
      rd_word[buck1_pkg::SLOT_LSB +: 3] = buck1_sleep_timeslot_q;
      rd_word[buck1_pkg::MODE_LSB +: 2] = buck1_sleep_opmode_q;
      rd_word[6:0] = buck1_sleep_voltage_code_q;
    end else if (hit_scaling) begin
      rd_word[buck1_pkg::SRC_LSB +: 2] = buck1_scaling_source_q;
      rd_word[6:0] = buck1_scaling_voltage_code_q;
    end else if (hit_status) begin
      rd_word = status_word;
    end
  end

  // Bus answer: one wait state, then a one-cycle pready
  always_comb begin
    pready_d = psel && penable && !pready_q;
    pslverr_d = pready_d && !mapped;
    prdata_d = prdata_q;
    if (pready_d) begin
      prdata_d = (pwrite || !mapped) ? 32'h0000_0000 : {16'h0000, rd_word};
    end
  end

  // Field next values; boot load overrides on-code bits 6:2 of a same-cycle bus write
  always_comb begin
    buck1_on_timeslot_d = buck1_on_timeslot_q;
    buck1_on_opmode_d = buck1_on_opmode_q;
    buck1_on_voltage_code_d = buck1_on_voltage_code_q;
    buck1_sleep_timeslot_d = buck1_sleep_timeslot_q;
    buck1_sleep_opmode_d = buck1_sleep_opmode_q;
    buck1_sleep_voltage_code_d = buck1_sleep_voltage_code_q;
    buck1_scaling_source_d = buck1_scaling_source_q;
    buck1_scaling_voltage_code_d = buck1_scaling_voltage_code_q;
    buck1_ramp_rate_d = buck1_ramp_rate_q;
    if (wr_en && hit_ramp) begin
      buck1_ramp_rate_d = pwdata[buck1_pkg::RATE_LSB +: 2];
    end
    if (wr_en && hit_on) begin
      buck1_on_timeslot_d = pwdata[buck1_pkg::SLOT_LSB +: 3];
      buck1_on_opmode_d = pwdata[buck1_pkg::MODE_LSB +: 2];
      buck1_on_voltage_code_d = pwdata[6:0];
    end
    if (wr_en && hit_sleep) begin
      buck1_sleep_timeslot_d = pwdata[buck1_pkg::SLOT_LSB +: 3];
      buck1_sleep_opmode_d = pwdata[buck1_pkg::MODE_LSB +: 2];
      buck1_sleep_voltage_code_d = pwdata[6:0];
    end
    if (wr_en && hit_scaling) begin
      buck1_scaling_source_d = pwdata[buck1_pkg::SRC_LSB +: 2];
      buck1_scaling_voltage_code_d = pwdata[6:0];
    end
    if (boot_load_pulse) begin
      // Boot memory only holds the coarse 50 mV part
      buck1_on_voltage_code_d[6:buck1_pkg::VHI_LSB] = boot_on_vsel_hi;
    end
  end

  // Register and bus state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buck1_on_timeslot_q <= buck1_pkg::ON_SLOT_RST;
      buck1_on_opmode_q <= buck1_pkg::ON_MODE_RST;
      buck1_on_voltage_code_q <= buck1_pkg::ON_VSEL_RST;
      buck1_sleep_timeslot_q <= buck1_pkg::SLEEP_SLOT_RST;
      buck1_sleep_opmode_q <= buck1_pkg::SLEEP_MODE_RST;
      buck1_sleep_voltage_code_q <= buck1_pkg::SLEEP_VSEL_RST;
      buck1_scaling_source_q <= buck1_pkg::SRC_RST;
      buck1_scaling_voltage_code_q <= buck1_pkg::SCALING_VSEL_RST;
      buck1_ramp_rate_q <= buck1_pkg::RATE_RST;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      buck1_on_timeslot_q <= buck1_on_timeslot_d;
      buck1_on_opmode_q <= buck1_on_opmode_d;
      buck1_on_voltage_code_q <= buck1_on_voltage_code_d;
      buck1_sleep_timeslot_q <= buck1_sleep_timeslot_d;
      buck1_sleep_opmode_q <= buck1_sleep_opmode_d;
      buck1_sleep_voltage_code_q <= buck1_sleep_voltage_code_d;
      buck1_scaling_source_q <= buck1_scaling_source_d;
      buck1_scaling_voltage_code_q <= buck1_scaling_voltage_code_d;
      buck1_ramp_rate_q <= buck1_ramp_rate_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ****************************************************************
  // Sequencing
  // ****************************************************************
  logic enable_q, enable_d;
  logic sleeping_q, sleeping_d;
  logic hw_assigned;
  logic slot_sequenced;
  logic sleep_code_disable;
  logic [2:0] sleep_slot;
  logic sleep_now;

  assign hw_assigned = (buck1_on_timeslot_q == buck1_pkg::SLOT_HWEN1) ||
                       (buck1_on_timeslot_q == buck1_pkg::SLOT_HWEN2);
  assign slot_sequenced = (buck1_on_timeslot_q != buck1_pkg::SLOT_OFF) && !hw_assigned;
  assign sleep_code_disable = (buck1_sleep_timeslot_q != buck1_pkg::SLP_TS5) &&
                              (buck1_sleep_timeslot_q <= buck1_pkg::SLOT_LAST);

  // Slot in which sleep entry acts for this code
  always_comb begin
    case (buck1_sleep_timeslot_q)
      buck1_pkg::SLP_TS5: sleep_slot = buck1_pkg::SLOT_NUM_5;
      buck1_pkg::SLP_TS3: sleep_slot = buck1_pkg::SLOT_NUM_3;
      buck1_pkg::SLP_TS1: sleep_slot = buck1_pkg::SLOT_NUM_1;
      default: sleep_slot = buck1_pkg::SLP_DIS_BASE - buck1_sleep_timeslot_q;
    endcase
  end

  assign sleep_now = seq_sleep_pulse && (seq_slot == sleep_slot);

  // Enable and sleep state
  always_comb begin
    enable_d = enable_q;
    sleeping_d = sleeping_q;
    if (buck1_on_timeslot_q == buck1_pkg::SLOT_OFF) begin
      enable_d = 1'b0;
    end else if (buck1_on_timeslot_q == buck1_pkg::SLOT_HWEN1) begin
      enable_d = hwen1_s;
    end else if (buck1_on_timeslot_q == buck1_pkg::SLOT_HWEN2) begin
      enable_d = hwen2_s;
    end else if (seq_startup_pulse && (seq_slot == buck1_on_timeslot_q)) begin
      enable_d = 1'b1;
      sleeping_d = 1'b0;
    end
    if (seq_wake_pulse) begin
      sleeping_d = 1'b0;
    end
    if (sleep_now) begin
      if (sleep_code_disable && slot_sequenced) begin
        enable_d = 1'b0;
      end else begin
        // Hardware-owned converters only change to sleep settings
        sleeping_d = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= 1'b0;
      sleeping_q <= 1'b0;
    end else begin
      enable_q <= enable_d;
      sleeping_q <= sleeping_d;
    end
  end

  // ****************************************************************
  // Target selection and ramp
  // ****************************************************************
  logic scaling_active;
  logic [6:0] raw_target;
  logic [6:0] clamped_target;
  logic [1:0] opmode_sel;

  // Scaling request per source
  always_comb begin
    case (buck1_scaling_source_q)
      buck1_pkg::SRC_SOFTWARE: scaling_active = 1'b1;
      buck1_pkg::SRC_HW1: scaling_active = hwsc1_s;
      buck1_pkg::SRC_HW2: scaling_active = hwsc2_s;
      default: scaling_active = 1'b0;
    endcase
  end

  // Sleep wins over scaling, scaling over the on code
  always_comb begin
    if (sleeping_q) begin
      raw_target = buck1_sleep_voltage_code_q;
      opmode_sel = buck1_sleep_opmode_q;
    end else if (scaling_active) begin
      raw_target = buck1_scaling_voltage_code_q;
      opmode_sel = buck1_on_opmode_q;
    end else begin
      raw_target = buck1_on_voltage_code_q;
      opmode_sel = buck1_on_opmode_q;
    end
    // Clamp so the ramp never spends steps on codes with no effect
    if (raw_target < buck1_pkg::VSEL_MIN_CODE) begin
      clamped_target = buck1_pkg::VSEL_MIN_CODE;
    end else if (raw_target > buck1_pkg::VSEL_MAX_CODE) begin
      clamped_target = buck1_pkg::VSEL_MAX_CODE;
    end else begin
      clamped_target = raw_target;
    end
  end

  buck1_ramp_if rif ();
  assign rif.target = clamped_target;
  assign rif.rate = buck1_pkg::ramp_rate_t'(buck1_ramp_rate_q);

  buck1_ramp u_ramp (
    .pclk(pclk),
    .presetn(presetn),
    .rif(rif)
  );

  // Converter outputs, registered
  logic [1:0] opmode_q;
  logic [6:0] vcode_q;
  logic settled_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opmode_q <= buck1_pkg::ON_MODE_RST;
      vcode_q <= buck1_pkg::VSEL_MIN_CODE;
      settled_q <= 1'b0;
    end else begin
      opmode_q <= opmode_sel;
      vcode_q <= rif.level;
      settled_q <= rif.settled;
    end
  end

  assign status_word = {1'b0, scaling_active, sleeping_q, enable_q, 2'b00, opmode_q,
                        1'b0, vcode_q};
  assign buck_enable = enable_q;
  assign buck_opmode = opmode_q;
  assign buck_voltage_code = vcode_q;
  assign buck_settled = settled_q;

endmodule

// *** buck1_ctrl_props.sv ***
// Port checker for the first buck converter control block
`timescale 1ns/1ps
module buck1_ctrl_props (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and sequencer
  input wire logic hw_enable1,
  input wire logic hw_enable2,
  input wire logic seq_startup_pulse,
  // Converter controls
  input wire logic buck_enable,
  input wire logic [1:0] buck_opmode,
  input wire logic [6:0] buck_voltage_code
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Access phase still waiting for its answer
  sequence acc_s;
    psel && penable && !pready;
  endsequence

  // Bus answer shape
  acc_ready_a: assert property (acc_s |=> pready) else $error("no ready after access");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
  err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  err_data_a: assert property (pslverr |-> prdata == 32'h0) else $error("data on error");
  upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0)
    else $error("upper read bits set");
  // Converter outputs; enable may only rise after a start pulse or a pin
  code_range_a: assert property (buck_voltage_code inside {[7'h08:7'h68]})
    else $error("voltage code out of range");
  reset_outs_a: assert property ($rose(presetn) |-> !buck_enable && buck_opmode == 2'h1)
    else $error("bad outputs after reset");
  enable_cause_a: assert property ($rose(buck_enable) |->
    $past(seq_startup_pulse) || $past(hw_enable1, 3) || $past(hw_enable2, 3))
    else $error("enable rose without cause");
endmodule

bind buck1_ctrl buck1_ctrl_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .hw_enable1(hw_enable1), .hw_enable2(hw_enable2), .seq_startup_pulse(seq_startup_pulse),
  .buck_enable(buck_enable), .buck_opmode(buck_opmode), .buck_voltage_code(buck_voltage_code));

// *** buck1_ctrl_tb.sv ***
// Self-checking bench for the first buck converter control block
`timescale 1ns/1ps
module buck1_ctrl_tb;
  // ****************************************************************
  // Stimulus, observed signals and the block
  // ****************************************************************
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [16:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic hw_enable1 = 0, hw_enable2 = 0, hw_scaling1 = 0, hw_scaling2 = 0;
  logic seq_startup_pulse = 0, seq_sleep_pulse = 0, seq_wake_pulse = 0, boot_load_pulse = 0;
  logic [2:0] seq_slot = '0;
  logic [4:0] boot_on_vsel_hi = '0;
  logic [31:0] prdata, r, q;
  logic pready, pslverr, buck_enable, buck_settled, e, b, p1, p2;
  logic [1:0] buck_opmode, m, mo;
  logic [6:0] buck_voltage_code, v, a;
  logic [14:0] ix [4] = '{buck1_pkg::ON_CFG_IDX, buck1_pkg::SLEEP_CTRL_IDX,
    buck1_pkg::SCALING_CTRL_IDX, buck1_pkg::RAMP_CTRL_IDX};
  logic [31:0] rv [3] = '{32'h0100, 32'h0300, 32'h0};
  logic [31:0] mk [3] = '{32'hE37F, 32'hE37F, 32'h187F};
  int n_mismatch = 0, comparisons = 0, n, t;

  buck1_ctrl i_buck1_ctrl (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .hw_enable1, .hw_enable2, .hw_scaling1, .hw_scaling2, .seq_startup_pulse,
    .seq_sleep_pulse, .seq_wake_pulse, .seq_slot, .boot_load_pulse, .boot_on_vsel_hi,
    .buck_enable, .buck_opmode, .buck_voltage_code, .buck_settled
  );

  // 100 MHz clock
  always #5 pclk = ~pclk;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [6:0] clamp(input logic [6:0] c);
    return (c < 7'h08) ? 7'h08 : ((c > 7'h68) ? 7'h68 : c);
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, s, x);
    end
  endtask

  // One APB transfer; waits for ready, no fixed latency assumed
  task automatic apb(input logic w, input logic [14:0] i, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for ready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [14:0] i, input logic [15:0] d);
    apb(1'b1, i, {16'h0, d});
  endtask

  task automatic rd(input logic [14:0] i);
    apb(1'b0, i, 32'h0);
  endtask

  // Sequencer event: 0 start, 1 sleep, 2 wake
  task automatic pulse(input int k, input logic [2:0] s);
    seq_slot <= s;
    seq_startup_pulse <= (k == 0);
    seq_sleep_pulse <= (k == 1);
    seq_wake_pulse <= (k == 2);
    @(posedge pclk);
    {seq_startup_pulse, seq_sleep_pulse, seq_wake_pulse} <= 3'h0;
    @(posedge pclk);
  endtask

  task automatic rst();
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  // Fresh start in slot 1 with immediate ramp, so voltages land quickly
  task automatic up(input logic [1:0] md, input logic [6:0] cd);
    rst();
    wr(ix[3], 16'hC000);
    wr(ix[0], {3'h1, 3'h0, md, 1'b0, cd});
    pulse(0, 3'h1);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Watchdog sized well above the ramp scenarios
  initial begin
    #400000;
    n_mismatch++;
    results();
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    @(posedge pclk);
    n = $urandom(48859);
    rst();
    chk(32'(buck_opmode), 32'h1);
    chk(32'(buck_voltage_code), 32'h08);
    chk(32'(buck_enable), 32'h0);
    // Reset values and reserved bits of the on, sleep and scaling registers
    for (int i = 0; i < 3; i++) begin
      rd(ix[i]);
      chk(r, rv[i]);
      apb(1'b1, ix[i], 32'hFFFF_FFFF);
      rd(ix[i]);
      chk(r, mk[i]);
    end
    apb(1'b0, 15'h4061, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    // Every on slot code with random mode and voltage
    for (int s = 0; s < 8; s++) begin
      rst();
      m = 2'($urandom);
      v = 7'($urandom);
      b = 1'($urandom);
      hw_enable1 <= b;
      hw_enable2 <= !b;
      wr(ix[3], 16'hC000);
      wr(ix[0], {s[2:0], 3'h0, m, 1'b0, v}); // No 4 MHz switching, any code legal
      t = (s == 0 || s > 5) ? 1 : s;
      pulse(0, 3'(t % 5 + 1));
      p2 = (s == 6) ? b : ((s == 7) ? !b : 1'b0);
      chk(32'(buck_enable), 32'(p2));
      pulse(0, 3'(t));
      repeat (3) @(posedge pclk);
      p1 = (s == 6) ? b : ((s == 7) ? !b : (s != 0));
      chk(32'(buck_enable), 32'(p1));
      if (p1) begin
        chk(32'(buck_opmode), 32'(m));
        chk(32'(buck_voltage_code), 32'(clamp(v)));
        chk(32'(buck_settled), 32'h1);
      end
      hw_enable1 <= !b;
      hw_enable2 <= b;
      repeat (4) @(posedge pclk);
      p2 = (s == 6) ? !b : b;
      if (s > 5) chk(32'(buck_enable), 32'(p2));
    end
    // Every sleep slot code after a software start
    for (int c = 0; c < 8; c++) begin
      m = 2'($urandom);
      mo = ~m;
      v = 7'($urandom);
      up(mo, v ^ 7'h40);
      wr(ix[1], {c[2:0], 3'h0, m, 1'b0, v});
      t = (c == 0) ? 5 : (c == 6) ? 3 : (c == 7) ? 1 : 6 - c;
      pulse(1, 3'(t % 5 + 1));
      chk(32'(buck_enable), 32'h1);
      chk(32'(buck_opmode), 32'(mo));
      pulse(1, 3'(t));
      repeat (3) @(posedge pclk);
      if (c > 0 && c < 6) begin
        chk(32'(buck_enable), 32'h0);
      end else begin
        chk(32'(buck_opmode), 32'(m));
        chk(32'(buck_voltage_code), 32'(clamp(v)));
        pulse(2, 3'h1);
        repeat (3) @(posedge pclk);
        chk(32'(buck_opmode), 32'(mo));
      end
    end
    // Sleep entry while on a hardware enable
    rst();
    hw_enable1 <= 1'b1;
    wr(ix[0], 16'hC100);
    wr(ix[1], 16'h4300);
    repeat (4) @(posedge pclk);
    chk(32'(buck_enable), 32'h1);
    pulse(1, 3'h4);
    rd(buck1_pkg::STATUS_IDX);
    chk(32'(r[13:12]), 32'h3);
    chk(32'(buck_opmode), 32'h3);
    // Scaling sources; on and scaling codes kept apart so a wrong pick shows
    a = 7'($urandom) & 7'h3F;
    v = 7'($urandom) | 7'h40;
    up(2'h0, a);
    for (int k = 0; k < 8; k++) begin
      p1 = 1'($urandom);
      p2 = 1'($urandom);
      hw_scaling1 <= p1;
      hw_scaling2 <= p2;
      wr(ix[2], {3'h0, 2'(k % 4), 4'h0, v});
      repeat (4) @(posedge pclk);
      b = (k % 4 == 1) || (k % 4 == 2 && p1) || (k % 4 == 3 && p2);
      chk(32'(buck_voltage_code), 32'(clamp(b ? v : a)));
      rd(buck1_pkg::STATUS_IDX);
      chk(32'(r[14]), 32'(b));
    end
    // Boot load replaces only the coarse part of the on code
    rd(ix[0]);
    q = r;
    boot_on_vsel_hi <= 5'h15;
    boot_load_pulse <= 1'b1;
    @(posedge pclk);
    boot_load_pulse <= 1'b0;
    rd(ix[0]);
    chk(r, {q[31:7], 5'h15, q[1:0]});
    // Spacing between two ramp steps at each timed rate
    for (int k = 0; k < 3; k++) begin
      up(2'h0, 7'h08);
      wr(ix[3], {2'(k), 14'h0});
      wr(ix[0], 16'h200C);
      n = 0;
      while (buck_voltage_code === 7'h08 && n < 4000) begin
        @(posedge pclk);
        n++;
      end
      v = buck_voltage_code;
      n = 0;
      while (buck_voltage_code === v && n < 4000) begin
        @(posedge pclk);
        n++;
      end
      t = buck1_pkg::CYC_32US >> k;
      chk(32'(n >= t && n <= t + 2), 32'h1);
    end
    results();
  end
endmodule
